// ---- rtl/drive_reference_source_selector.sv ----
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "drive_ref_defines.svh"
module drive_reference_source_selector
  import drive_ref_pkg::*;
#(
  parameter int AW   = 12,
  parameter int NANA = 5
)(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output var  logic                   wb_ack_o,
  output var  logic [31:0]            wb_dat_o,
  input  wire logic [7:0]             multifunctionIn,
  input  wire logic [NANA-1:0][AW-1:0] analogRaw,
  input  wire value_t                 freqRef,
  input  wire value_t                 serialRef,
  input  wire value_t                 fieldbusRef,
  input  wire value_t                 keypadRef,
  input  wire value_t                 encoderRef,
  input  wire value_t                 upDownRef,
  input  wire value_t                 torqueDemand,
  input  wire logic [5:0]             cmdRun,
  input  wire logic                   localRequest,
  input  wire logic                   driveRunning,
  output value_t                      speedRefOut,
  output value_t                      torqueOut,
  output value_t                      torqueLimitOut,
  output var  logic [2:0]             activeCmdSource,
  output var  logic                   runCmd,
  output var  logic                   localMode,
  output var  logic signed [2:0][15:0] pidSourceValue
);
  localparam int NCFG = 18;

  cfg_word_t  cfgReg [0:NCFG-1];
  logic       ack_reg;
  logic [31:0] readData;
  ctrl_mode_t mode_reg;
  logic       holdRef_reg;
  logic       keepRun_reg;
  value_t     heldRef_reg;
  sum_t       lo_reg;
  sum_t       hi_reg;
  value_t     scaled [0:NANA-1];
  logic [4:0] idx;
  logic       busReq;
  logic [3:0] selCfg;
  logic       selIn;
  sum_t       refSum;
  sum_t       speedPre;
  sum_t       speedBound;
  sum_t       maxAbsTorque;
  sum_t       limitNext;
  logic [3:0] tlimCode;
  logic       mayChange;
  logic [2:0] activeCmd_next;
  logic       runCmd_next;

  scale_if sIf ();

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // reset value of each configuration word
  function automatic cfg_word_t cfgReset(input int i);
    case (i)
      `IDX_SEL_CFG:    cfgReset = `RST_SEL_CFG;
      `IDX_CMD_ONE:    cfgReset = `RST_CMD_ONE;
      `IDX_CMD_TWO:    cfgReset = `RST_CMD_TWO;
      `IDX_REF_ONE:    cfgReset = `RST_REF_ONE;
      `IDX_REF_TWO:    cfgReset = `RST_REF_TWO;
      `IDX_TLIM_SRC:   cfgReset = `RST_TLIM_SRC;
      `IDX_LOCREM:     cfgReset = `RST_LOCREM;
      `IDX_MIN_TORQUE: cfgReset = `RST_MIN_TORQUE;
      `IDX_MAX_TORQUE: cfgReset = `RST_MAX_TORQUE;
      `IDX_MIN_SPEED:  cfgReset = `RST_MIN_SPEED;
      `IDX_MAX_SPEED:  cfgReset = `RST_MAX_SPEED;
      `IDX_PCT_MIN:    cfgReset = `RST_PCT;
      `IDX_PCT_MAX:    cfgReset = `RST_PCT;
      default:         cfgReset = `RST_REF_OFF;
    endcase
  endfunction

  // source code fields accept only their legal range
  function automatic logic codeOk(input int i, input cfg_word_t v);
    if (i >= int'(`IDX_REF_ONE) && i <= int'(`IDX_TLIM_SRC))
      codeOk = (v <= 16'(`CODE_AUX_I));
    else if (i >= int'(`IDX_PID_FIRST) && i <= int'(`IDX_PID_LAST))
      codeOk = (v <= 16'(`CODE_AUX_I));
    else if (i == int'(`IDX_CMD_ONE) || i == int'(`IDX_CMD_TWO))
      codeOk = (v <= `CMD_LAST);
    else if (i == int'(`IDX_SEL_CFG))
      codeOk = (v <= `SEL_LAST);
    else
      codeOk = 1'b1;
  endfunction

  // value delivered by a reference or limit source code
  function automatic value_t srcValue(input logic [3:0] code);
    case (code)
      `CODE_ANA_SINGLE: srcValue = scaled[0];
      `CODE_DIFF_A:     srcValue = scaled[1];
      `CODE_DIFF_B:     srcValue = scaled[2];
      `CODE_FREQ:       srcValue = freqRef;
      `CODE_SERIAL:     srcValue = serialRef;
      `CODE_FIELDBUS:   srcValue = fieldbusRef;
      `CODE_KEYPAD:     srcValue = keypadRef;
      `CODE_ENCODER:    srcValue = encoderRef;
      `CODE_UPDOWN:     srcValue = upDownRef;
      `CODE_AUX_V:      srcValue = scaled[3];
      `CODE_AUX_I:      srcValue = scaled[4];
      default:          srcValue = 16'sh0000;
    endcase
  endfunction

  function automatic sum_t absVal(input sum_t v);
    absVal = (v < 0) ? -v : v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  assign busReq = wb_cyc_i & wb_stb_i;
  assign idx    = wb_adr_i[6:2];

  // single-cycle ack, dropped after one cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= busReq & ~ack_reg;
  end
  assign wb_ack_o = ack_reg;

  // read multiplexer, unmapped addresses read zero
  always_comb
  begin
    readData = 32'h0000_0000;
    if (!wb_adr_i[7])
    begin
      if (idx < 5'(NCFG))
        readData = {16'h0000, cfgReg[idx]};
      else if (idx == `IDX_STATUS)
        readData = {26'h0000000, localMode, selIn, runCmd, activeCmdSource};
      else if (idx == `IDX_SPEED_OUT)
        readData = {16'h0000, speedRefOut};
      else if (idx == `IDX_TLIM_OUT)
        readData = {16'h0000, torqueLimitOut};
    end
  end

  // read data captured with the ack
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h0000_0000;
    else if (busReq & ~ack_reg)
      wb_dat_o <= readData;
  end

  // configuration words, written at the acked edge, byte lanes honoured
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NCFG; i++)
        cfgReg[i] <= cfgReset(i);
    end
    else if (busReq & ack_reg & wb_we_i & ~wb_adr_i[7] & (idx < 5'(NCFG)))
    begin
      if (codeOk(int'(idx), {wb_sel_i[1] ? wb_dat_i[15:8] : cfgReg[idx][15:8],
                             wb_sel_i[0] ? wb_dat_i[7:0] : cfgReg[idx][7:0]}))
      begin
        if (wb_sel_i[0])
          cfgReg[idx][7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          cfgReg[idx][15:8] <= wb_dat_i[15:8];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog scaling

  // speed end points from percentages of minimum and maximum speed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lo_reg <= 32'sh0000_0000;
      hi_reg <= 32'sh0000_0000;
    end
    else
    begin
      lo_reg <= sum_t'(signed'(cfgReg[`IDX_MIN_SPEED]))
                * sum_t'(signed'({1'b0, cfgReg[`IDX_PCT_MIN]})) / `PCT_FULL;
      hi_reg <= sum_t'(signed'(cfgReg[`IDX_MAX_SPEED]))
                * sum_t'(signed'({1'b0, cfgReg[`IDX_PCT_MAX]})) / `PCT_FULL;
    end
  end
  assign sIf.lo = lo_reg;
  assign sIf.hi = hi_reg;

  // one scaler per analog input
  generate
    for (genvar g = 0; g < NANA; g++)
    begin : gScale
      analog_ref_scaler #(.AW(AW)) uScale (
        .clk    (clk),
        .rst_n  (rst_n),
        .cfg    (sIf),
        .raw    (analogRaw[g]),
        .scaled (scaled[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // reference selection and summation

  assign selCfg = cfgReg[`IDX_SEL_CFG][3:0];
  assign selIn  = (selCfg != 4'h0) && multifunctionIn[3'(selCfg - 4'h1)];

  // enabled sources added in 32 bits so nothing wraps before saturation
  always_comb
  begin
    refSum = sum_t'(srcValue(cfgReg[`IDX_REF_THREE][3:0]))
           + sum_t'(srcValue(cfgReg[`IDX_REF_FOUR][3:0]));
    if (selCfg == 4'h0)
      refSum = refSum + sum_t'(srcValue(cfgReg[`IDX_REF_ONE][3:0]))
             + sum_t'(srcValue(cfgReg[`IDX_REF_TWO][3:0]));
    else if (selIn)
      refSum = refSum + sum_t'(srcValue(cfgReg[`IDX_REF_TWO][3:0]));
    else
      refSum = refSum + sum_t'(srcValue(cfgReg[`IDX_REF_ONE][3:0]));
    if (mode_reg == MODE_LOCAL)
      speedPre = holdRef_reg ? sum_t'(heldRef_reg) : sum_t'(keypadRef);
    else
      speedPre = refSum;
    speedBound = absVal(sum_t'(signed'(cfgReg[`IDX_MAX_SPEED])));
  end

  // speed reference saturated at maximum speed
  sym_clamp uSpeedClamp (
    .clk     (clk),
    .rst_n   (rst_n),
    .value   (speedPre),
    .bound   (speedBound),
    .clamped (speedRefOut)
  );

  //////////////////////////////////////////////////////////////////////////////
  // torque limit

  assign tlimCode = cfgReg[`IDX_TLIM_SRC][3:0];

  // default limit is the larger absolute torque bound
  always_comb
  begin
    maxAbsTorque = absVal(sum_t'(signed'(cfgReg[`IDX_MIN_TORQUE])));
    if (absVal(sum_t'(signed'(cfgReg[`IDX_MAX_TORQUE]))) > maxAbsTorque)
      maxAbsTorque = absVal(sum_t'(signed'(cfgReg[`IDX_MAX_TORQUE])));
    if (tlimCode == `CODE_DISABLED)
      limitNext = maxAbsTorque;
    else
      limitNext = absVal(sum_t'(srcValue(tlimCode)));
  end

  // registered limit, also the clamp bound
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      torqueLimitOut <= 16'sh0000;
    else
      torqueLimitOut <= 16'(limitNext);
  end

  // torque demand clamped to plus and minus the limit
  sym_clamp uTorqueClamp (
    .clk     (clk),
    .rst_n   (rst_n),
    .value   (sum_t'(torqueDemand)),
    .bound   (sum_t'(torqueLimitOut)),
    .clamped (torqueOut)
  );

  //////////////////////////////////////////////////////////////////////////////
  // remote and local mode

  assign mayChange = ~driveRunning | cfgReg[`IDX_LOCREM][`LR_RUN_BIT];

  // mode switch with optional hold of run state and reference
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_reg    <= MODE_REMOTE;
      holdRef_reg <= 1'b0;
      keepRun_reg <= 1'b0;
      heldRef_reg <= 16'sh0000;
    end
    else
    begin
      case (mode_reg)
        MODE_REMOTE:
          if (localRequest && mayChange)
          begin
            mode_reg    <= MODE_LOCAL;
            holdRef_reg <= cfgReg[`IDX_LOCREM][`LR_KEEP_BIT];
            keepRun_reg <= cfgReg[`IDX_LOCREM][`LR_KEEP_BIT] & runCmd;
            heldRef_reg <= speedRefOut;
          end
        MODE_LOCAL:
          if (!localRequest && mayChange)
          begin
            mode_reg    <= MODE_REMOTE;
            holdRef_reg <= 1'b0;
            keepRun_reg <= 1'b0;
          end
        default:
          mode_reg <= MODE_REMOTE;
      endcase
    end
  end

  // command source and run request
  always_comb
  begin
    if (mode_reg == MODE_LOCAL)
      activeCmd_next = `CMD_KEYPAD;
    else if (selIn)
      activeCmd_next = cfgReg[`IDX_CMD_TWO][2:0];
    else
      activeCmd_next = cfgReg[`IDX_CMD_ONE][2:0];
    runCmd_next = (activeCmd_next != 3'h0) & cmdRun[activeCmd_next];
    if (mode_reg == MODE_LOCAL)
      runCmd_next = runCmd_next | keepRun_reg;
  end

  // registered command outputs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      activeCmdSource <= 3'h0;
      runCmd          <= 1'b0;
      localMode       <= 1'b0;
    end
    else
    begin
      activeCmdSource <= activeCmd_next;
      runCmd          <= runCmd_next;
      localMode       <= (mode_reg == MODE_LOCAL);
    end
  end

  // controller source values, silent in local mode
  generate
    for (genvar k = 0; k < 3; k++)
    begin : gPid
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          pidSourceValue[k] <= 16'sh0000;
        else if (mode_reg == MODE_LOCAL)
          pidSourceValue[k] <= 16'sh0000;
        else
          pidSourceValue[k] <= srcValue(cfgReg[int'(`IDX_PID_FIRST) + k][3:0]);
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // checks

  ackPulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (busReq && !ack_reg) |=> ack_reg ##1 !ack_reg)
    else $error("ack not a single pulse after request");

  tlimReset_a: assert property (@(posedge clk)
    !rst_n |=> (cfgReg[`IDX_TLIM_SRC] == 16'h0000))
    else $error("torque limit source not zero after reset");

  defaultLimit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tlimCode == 4'h0) |=> (sum_t'(torqueLimitOut) == $past(maxAbsTorque)))
    else $error("default torque limit wrong");

  speedSat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (speedPre > speedBound) |=> (sum_t'(speedRefOut) == $past(speedBound)))
    else $error("speed reference not saturated");

  lockedMode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (driveRunning && !cfgReg[`IDX_LOCREM][`LR_RUN_BIT]) |=> $stable(mode_reg))
    else $error("mode changed while running");

  localKeypad_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_reg == MODE_LOCAL) |=> (activeCmdSource == `CMD_KEYPAD))
    else $error("local mode not on keypad");

  selectOne_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_reg == MODE_REMOTE && selCfg != 4'h0 && !selIn)
    |=> (activeCmdSource == $past(cfgReg[`IDX_CMD_ONE][2:0])))
    else $error("set one not chosen with selector open");

  codeReject_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |-> (cfgReg[`IDX_TLIM_SRC] <= 16'h000B))
    else $error("illegal torque limit source code stored");
endmodule
`default_nettype wire

// ---- rtl/drive_ref_defines.svh ----
`ifndef DRIVE_REF_DEFINES_SVH
`define DRIVE_REF_DEFINES_SVH

// register indices, byte address is four times the index
`define IDX_SEL_CFG     5'h00
`define IDX_CMD_ONE     5'h01
`define IDX_CMD_TWO     5'h02
`define IDX_REF_ONE     5'h03
`define IDX_REF_TWO     5'h04
`define IDX_REF_THREE   5'h05
`define IDX_REF_FOUR    5'h06
`define IDX_TLIM_SRC    5'h07
`define IDX_LOCREM      5'h08
`define IDX_PID_FIRST   5'h09
`define IDX_PID_LAST    5'h0B
`define IDX_MIN_TORQUE  5'h0C
`define IDX_MAX_TORQUE  5'h0D
`define IDX_MIN_SPEED   5'h0E
`define IDX_MAX_SPEED   5'h0F
`define IDX_PCT_MIN     5'h10
`define IDX_PCT_MAX     5'h11
`define IDX_STATUS      5'h12
`define IDX_SPEED_OUT   5'h13
`define IDX_TLIM_OUT    5'h14

// reset values of the configuration words
`define RST_SEL_CFG     16'h0006
`define RST_CMD_ONE     16'h0001
`define RST_CMD_TWO     16'h0001
`define RST_REF_ONE     16'h0001
`define RST_REF_TWO     16'h0002
`define RST_REF_OFF     16'h0000
`define RST_TLIM_SRC    16'h0000
`define RST_LOCREM      16'h0000
`define RST_PID         16'h0000
`define RST_MIN_TORQUE  16'h0000
`define RST_MAX_TORQUE  16'h04B0
`define RST_MIN_SPEED   16'h0000
`define RST_MAX_SPEED   16'h05DC
`define RST_PCT         16'h03E8

// source codes
`define CODE_DISABLED   4'h0
`define CODE_ANA_SINGLE 4'h1
`define CODE_DIFF_A     4'h2
`define CODE_DIFF_B     4'h3
`define CODE_FREQ       4'h4
`define CODE_SERIAL     4'h5
`define CODE_FIELDBUS   4'h6
`define CODE_KEYPAD     4'h7
`define CODE_ENCODER    4'h8
`define CODE_UPDOWN     4'h9
`define CODE_AUX_V      4'hA
`define CODE_AUX_I      4'hB
`define CMD_KEYPAD      3'h5
`define CMD_LAST        16'h0005
`define SEL_LAST        16'h0008

// switch-over configuration bits
`define LR_RUN_BIT      0
`define LR_KEEP_BIT     1

// scaling: percentage in tenths, full-scale analog count
`define PCT_FULL        32'sd1000
`define ANALOG_FULL     48'sd4095

`endif

// ---- rtl/drive_ref_pkg.sv ----
package drive_ref_pkg;
  typedef logic signed [15:0] value_t;
  typedef logic        [15:0] cfg_word_t;
  typedef logic signed [31:0] sum_t;
  typedef enum logic {MODE_REMOTE, MODE_LOCAL} ctrl_mode_t;
endpackage

// ---- rtl/scale_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// speed end points shared by all analog scalers
interface scale_if;
  import drive_ref_pkg::*;
  sum_t lo;
  sum_t hi;
  modport src (output lo, hi);
  modport dst (input lo, hi);
endinterface
`default_nettype wire

// ---- rtl/analog_ref_scaler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drive_ref_defines.svh"
module analog_ref_scaler
  import drive_ref_pkg::*;
#(
  parameter int AW = 12
)(
  input  wire logic          clk,
  input  wire logic          rst_n,
  scale_if.dst               cfg,
  input  wire logic [AW-1:0] raw,
  output value_t             scaled
);
  logic signed [47:0] prod;
  logic signed [47:0] quot;

  // linear map from zero..full scale onto lo..hi
  always_comb
  begin
    prod = 48'(cfg.hi - cfg.lo) * 48'(signed'({1'b0, raw}));
    quot = prod / `ANALOG_FULL;
  end

  // registered scaled value
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      scaled <= 16'sh0000;
    else
      scaled <= 16'(cfg.lo + 32'(quot));
  end
endmodule
`default_nettype wire

// ---- rtl/sym_clamp.sv ----
`timescale 1ns/1ps
`default_nettype none
module sym_clamp
  import drive_ref_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire sum_t value,
  input  wire sum_t bound,
  output value_t    clamped
);
  // symmetric saturation against a non-negative bound
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clamped <= 16'sh0000;
    else if (value > bound)
      clamped <= 16'(bound);
    else if (value < -bound)
      clamped <= 16'(-bound);
    else
      clamped <= 16'(value);
  end

  clampRange_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> (sum_t'(clamped) <= $past(bound)) && (sum_t'(clamped) >= -$past(bound)))
    else $error("clamped value outside bound");
endmodule
`default_nettype wire

// ---- bench/drive_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module drive_source_model
  import drive_ref_pkg::*;
(
  output var logic [4:0][11:0] analogRaw,
  output value_t               freqRef,
  output value_t               serialRef,
  output value_t               fieldbusRef,
  output value_t               keypadRef,
  output value_t               encoderRef,
  output value_t               upDownRef
);
  // steady source levels; analog counts scale to whole values without remainder
  always_comb
  begin
    analogRaw   = {12'hFFF, 12'h333, 12'h555, 12'hAAA, 12'h111};
    freqRef     = 16'h0032;
    serialRef   = 16'h0064;
    fieldbusRef = 16'h00C8;
    keypadRef   = 16'hFED4;
    encoderRef  = 16'h0578;
    upDownRef   = 16'hFFBA;
  end
endmodule
`default_nettype wire

// ---- bench/drive_reference_source_selector_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module drive_reference_source_selector_tb_top
  import drive_ref_pkg::*;
;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic [3:0]       sel = 4'h0;
  logic [31:0]      datW = 32'h0;
  logic             ack;
  logic [31:0]      datR;
  logic [7:0]       mfIn = 8'h00;
  logic [4:0][11:0] analogRaw;
  value_t           freqRef, serialRef, fieldbusRef, keypadRef, encoderRef, upDownRef;
  value_t           torqueDemand = 16'h0000;
  logic [5:0]       cmdRun = 6'h00;
  logic             localRequest = 1'b0;
  logic             driveRunning = 1'b0;
  value_t           speedRefOut, torqueOut, torqueLimitOut;
  logic [2:0]       activeCmdSource;
  logic             runCmd, localMode;
  logic signed [2:0][15:0] pidVal;
  int               num_errors = 0;
  int               n_compared = 0;
  logic [31:0]      rd;
  // absolute source value per torque limit code, code 0 is the larger torque bound
  localparam logic [15:0] LIM [12] = '{16'h04B0, 16'h0064, 16'h03E8, 16'h01F4, 16'h0032,
    16'h0064, 16'h00C8, 16'h012C, 16'h0578, 16'h0046, 16'h012C, 16'h05DC};

  // 100 ns clock
  always #50 clk = ~clk;

  drive_source_model i_src (.analogRaw(analogRaw), .freqRef(freqRef), .serialRef(serialRef),
    .fieldbusRef(fieldbusRef), .keypadRef(keypadRef), .encoderRef(encoderRef),
    .upDownRef(upDownRef));

  drive_reference_source_selector i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
    .wb_ack_o(ack), .wb_dat_o(datR), .multifunctionIn(mfIn), .analogRaw(analogRaw),
    .freqRef(freqRef), .serialRef(serialRef), .fieldbusRef(fieldbusRef),
    .keypadRef(keypadRef), .encoderRef(encoderRef), .upDownRef(upDownRef),
    .torqueDemand(torqueDemand), .cmdRun(cmdRun), .localRequest(localRequest),
    .driveRunning(driveRunning), .speedRefOut(speedRefOut), .torqueOut(torqueOut),
    .torqueLimitOut(torqueLimitOut), .activeCmdSource(activeCmdSource), .runCmd(runCmd),
    .localMode(localMode), .pidSourceValue(pidVal));

  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one classic cycle, held up to the rising edge at which ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    datW <= {16'h0000, d};
    do
      @(posedge clk);
    while (ack !== 1'b1);
    rd = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // let registered and analog paths settle
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_values();
    xfer(1'b0, 8'h00, 16'h0000);
    check(rd[15:0], 16'h0006, "selector reset");
    xfer(1'b0, 8'h10, 16'h0000);
    check(rd[15:0], 16'h0002, "ref two reset");
    xfer(1'b0, 8'h14, 16'h0000);
    check(rd[15:0], 16'h0000, "ref three reset");
    xfer(1'b0, 8'h1C, 16'h0000);
    check(rd[15:0], 16'h0000, "limit src reset");
    xfer(1'b0, 8'h84, 16'h0000);
    check(rd[15:0], 16'h0000, "unmapped read");
    check(torqueLimitOut, 16'h04B0, "default limit");
  endtask

  task automatic select_and_sum();
    xfer(1'b1, 8'h08, 16'h0003);
    cmdRun <= 6'h08;
    settle();
    check(speedRefOut, 16'h0064, "open selector ref");
    check({13'h0, activeCmdSource}, 16'h0001, "open selector cmd");
    @(posedge clk);
    mfIn <= 8'h20;
    settle();
    check(speedRefOut, 16'h03E8, "closed selector ref");
    check({13'h0, activeCmdSource}, 16'h0003, "closed selector cmd");
    check({15'h0, runCmd}, 16'h0001, "run from source two");
    xfer(1'b1, 8'h14, 16'h0004);
    settle();
    check(speedRefOut, 16'h041A, "ref three added");
    xfer(1'b1, 8'h00, 16'h0009);
    xfer(1'b0, 8'h00, 16'h0000);
    check(rd[15:0], 16'h0006, "bad selector code kept");
    xfer(1'b1, 8'h00, 16'h0000);
    settle();
    check(speedRefOut, 16'h047E, "sum of all");
    xfer(1'b1, 8'h18, 16'h0008);
    settle();
    check(speedRefOut, 16'h05DC, "sum saturated");
  endtask

  task automatic limit_codes();
    for (int c = 0; c < 12; c++)
    begin
      xfer(1'b1, 8'h1C, 16'(c));
      settle();
      check(torqueLimitOut, LIM[c], "limit per code");
    end
    xfer(1'b1, 8'h1C, 16'h000C);
    xfer(1'b0, 8'h1C, 16'h0000);
    check(rd[15:0], 16'h000B, "bad limit code kept");
    xfer(1'b1, 8'h1C, 16'h0007);
    @(posedge clk);
    torqueDemand <= 16'h01F4;
    settle();
    check(torqueOut, 16'h012C, "clamp high");
    @(posedge clk);
    torqueDemand <= 16'hFE0C;
    settle();
    check(torqueOut, 16'hFED4, "clamp low");
    @(posedge clk);
    torqueDemand <= 16'h00C8;
    settle();
    check(torqueOut, 16'h00C8, "inside limit");
  endtask

  task automatic local_remote();
    xfer(1'b1, 8'h24, 16'h0005);
    settle();
    check(pidVal[0], 16'h0064, "controller source");
    @(posedge clk);
    driveRunning <= 1'b1;
    localRequest <= 1'b1;
    settle();
    check({15'h0, localMode}, 16'h0000, "no change running");
    @(posedge clk);
    driveRunning <= 1'b0;
    settle();
    check({15'h0, localMode}, 16'h0001, "local when idle");
    check({13'h0, activeCmdSource}, 16'h0005, "keypad cmd");
    check(speedRefOut, 16'hFED4, "keypad ref");
    check(pidVal[0], 16'h0000, "controller silent in local");
    xfer(1'b1, 8'h20, 16'h0003);
    @(posedge clk);
    driveRunning <= 1'b1;
    localRequest <= 1'b0;
    cmdRun       <= 6'h02;
    settle();
    check({15'h0, localMode}, 16'h0000, "remote while running");
    check(speedRefOut, 16'h05DC, "remote sum again");
    check({15'h0, runCmd}, 16'h0001, "run from source one");
    @(posedge clk);
    localRequest <= 1'b1;
    settle();
    check({15'h0, localMode}, 16'h0001, "local while running");
    check(speedRefOut, 16'h05DC, "reference kept");
    check({15'h0, runCmd}, 16'h0001, "run kept");
  endtask

  // reset in mid-run with local requested and drive running
  task automatic mid_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check({15'h0, localMode}, 16'h0000, "remote after reset");
    check(torqueLimitOut, 16'h04B0, "limit after reset");
    check(speedRefOut, 16'h03E8, "factory source two");
    xfer(1'b0, 8'h1C, 16'h0000);
    check(rd[15:0], 16'h0000, "limit src after reset");
    xfer(1'b1, 8'h44, 16'h01F4);
    settle();
    check(speedRefOut, 16'h01F4, "max percentage halved");
    xfer(1'b1, 8'h38, 16'h0096);
    settle();
    check(speedRefOut, 16'h0226, "offset from min speed");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog well beyond the expected few hundred cycles
  initial
  begin
    #(5000 * 100);
    num_errors++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    reset_values();
    select_and_sum();
    limit_codes();
    local_remote();
    mid_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
